// *** core/psq_pkg.sv ***
// Package with constants and types for the program sequencer.
package psq_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int PSQ_PC_W = 12;
  localparam int PSQ_WORD_W = 15;
  localparam int PSQ_STACK_DEPTH = 6;
  localparam int PSQ_LVL_W = 3;

  // ----------------------------------------------------------------
  // Vectors and register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] PSQ_VEC_RESET = 12'h000;
  localparam logic [11:0] PSQ_VEC_SERIAL = 12'h004;
  localparam logic [11:0] PSQ_VEC_TIMER = 12'h008;
  localparam logic [11:0] PSQ_VEC_EXT = 12'h00C;
  localparam logic [3:0] PSQ_LAST_PAGE = 4'hF;
  localparam logic [7:0] PSQ_OFS_TBL_LOW = 8'h07;
  localparam logic [7:0] PSQ_OFS_TBL_HIGH = 8'h08;
  localparam logic [7:0] PSQ_OFS_TBL_PAGE = 8'h1F;
  localparam logic [7:0] PSQ_RST_TBL_LOW = 8'h00;
  localparam logic [7:0] PSQ_RST_TBL_HIGH = 8'h00;
  localparam logic [7:0] PSQ_RST_TBL_PAGE = 8'h00;
  localparam logic [2:0] PSQ_RST_LEVEL = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSQ_IRQ_SERIAL = 3'b001,
    PSQ_IRQ_TIMER = 3'b010,
    PSQ_IRQ_EXT = 3'b100
  } psq_irq_t;

  typedef enum logic [3:0] {
    PSQ_ST_RUN = 4'b0001,
    PSQ_ST_DUMMY = 4'b0010,
    PSQ_ST_TABLE = 4'b0100,
    PSQ_ST_IDLE = 4'b1000
  } psq_state_t;

  // One instruction cycle of decoded sequencing commands.
  typedef struct packed {
    logic exec;
    logic jump;
    logic call;
    logic ret;
    logic interrupt_return_instr;
    logic skip;
    logic pcl_wr;
    logic tab_cur;
    logic tab_last;
    logic [11:0] target;
  } psq_cmd_t;

  // Data-memory style register port.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psq_reg_req_t;

endpackage : psq_pkg

// *** core/psq_return_stack.sv ***
// Six-entry return stack holding program counter values only.
`timescale 1ns/1ps
module psq_return_stack (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] push_val,
  output logic [11:0] top_val,
  output logic full
);

  typedef struct packed {
    logic [2:0] level;
    logic [5:0][11:0] slot;
  } psq_stk_state_t;

  psq_stk_state_t st_q;
  psq_stk_state_t st_d;

  // ----------------------------------------------------------------
  // Stack update
  // ----------------------------------------------------------------
  // A push on a full stack still happens and overwrites the newest slot;
  // the overflow is silent, software has to avoid it.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.slot[(st_q.level == 3'd6) ? 3'd5 : st_q.level] = push_val;
      if (st_q.level != 3'd6) begin
        st_d.level = st_q.level + 3'd1;
      end
    end else if (pop && st_q.level != 3'd0) begin
      st_d.level = st_q.level - 3'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q.level <= psq_pkg::PSQ_RST_LEVEL;
      st_q.slot <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Level and contents are internal only; no register port exposes them.
  assign top_val = st_q.slot[(st_q.level == 3'd0) ? 3'd0 : st_q.level - 3'd1];
  assign full = (st_q.level == 3'd6);

  AST_LEVEL_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q.level <= 3'd6) else $error("stack level beyond six");

endmodule : psq_return_stack

// *** core/psq_table_addr.sv ***
// Table read address former for current page and last page reads.
`timescale 1ns/1ps
module psq_table_addr (
  input wire logic page_ext_en,
  input wire logic last_page,
  input wire logic [3:0] pc_high,
  input wire logic [7:0] tbl_low,
  input wire logic [7:0] tbl_page,
  output logic [11:0] addr
);

  // ----------------------------------------------------------------
  // Address selection
  // ----------------------------------------------------------------
  always_comb begin
    if (last_page) begin
      addr = {psq_pkg::PSQ_LAST_PAGE, tbl_low};
    end else if (page_ext_en) begin
      addr = {tbl_page[3:0], tbl_low};
    end else begin
      addr = {pc_high, tbl_low};
    end
  end

endmodule : psq_table_addr

// *** core/psq_sequencer.sv ***
// Program sequencer: program counter, return stack, vectors and table reads.
`timescale 1ns/1ps
//
// Contract
// - Six entry stack, hidden from software
// - Push PC on call and interrupt acknowledge
// - Return pops stack into PC
// - Reset empties the stack
// - Full stack latches request, defers acknowledge
// - Call on full stack still executes
// - Reset starts PC at 000H
// - Serial interrupt vectors to 004H
// - Timer overflow vectors to 008H
// - External falling edge vectors to 00CH
// - Low byte write keeps upper PC bits
// - Jump or call loads twelve-bit target
// - ALU result and status written back
// - Program memory 4096 by 15 words
// - Current page uses PC upper bits
// - Page extension uses page select low nibble
// - Last page read forces upper 1111
// - Low byte out, upper seven to high register
// - High register read-only, pointers read-write
// - Table read takes two cycles
// - PC advances by one per instruction
// - Branches insert one dummy cycle
// - Low byte jump stays in page
module psq_sequencer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire psq_pkg::psq_cmd_t cmd,
  input wire psq_pkg::psq_reg_req_t reg_req,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] alu_status,
  input wire logic alu_wr,
  input wire logic serial_done,
  input wire logic timer_ovf,
  input wire logic ext_int_n,
  input wire logic [2:0] irq_enable,
  input wire logic page_ext_en,
  input wire logic [14:0] pmem_rdata,
  output logic [11:0] pmem_addr,
  output logic [11:0] pc,
  output logic cycle_ready,
  output logic dummy_cycle,
  output logic irq_ack,
  output logic [11:0] irq_vector,
  output logic [2:0] irq_pending,
  output logic [7:0] reg_rdata,
  output logic tab_wr,
  output logic [7:0] tab_data,
  output logic [7:0] dest_data,
  output logic dest_wr,
  output logic [7:0] status_q
);

  typedef struct packed {
    psq_pkg::psq_state_t state;
    logic [11:0] pc;
    logic [11:0] pmem_addr;
    logic [7:0] tbl_low;
    logic [7:0] tbl_high;
    logic [7:0] tbl_page;
    logic [2:0] pend;
    logic ext_prev;
    logic cycle_ready;
    logic dummy;
    logic ack;
    logic [11:0] vector;
    logic [7:0] rdata;
    logic tab_wr;
    logic [7:0] tab_data;
    logic [7:0] dest_data;
    logic dest_wr;
    logic [7:0] status;
  } psq_seq_state_t;

  psq_seq_state_t s_q;
  psq_seq_state_t s_d;

  logic stk_push;
  logic stk_pop;
  logic [11:0] stk_push_val;
  logic [11:0] stk_top;
  logic stk_full;
  logic [11:0] tab_addr;
  logic [2:0] pend_now;
  logic take_irq;
  logic tbl_top_zero;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register read decode; unused offsets return zero.
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic [7:0] pg);
    case (addr)
      psq_pkg::PSQ_OFS_TBL_LOW: reg_read = lo;
      psq_pkg::PSQ_OFS_TBL_HIGH: reg_read = hi;
      psq_pkg::PSQ_OFS_TBL_PAGE: reg_read = pg;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Fixed priority: the lowest vector address wins.
  function automatic logic [2:0] lowest_first(input logic [2:0] req);
    if (req[0]) begin
      lowest_first = 3'b001;
    end else if (req[1]) begin
      lowest_first = 3'b010;
    end else begin
      lowest_first = {req[2], 2'b00};
    end
  endfunction : lowest_first

  // Vector of a one-hot grant.
  function automatic logic [11:0] vector_of(input logic [2:0] grant);
    case (grant)
      psq_pkg::PSQ_IRQ_SERIAL: vector_of = psq_pkg::PSQ_VEC_SERIAL;
      psq_pkg::PSQ_IRQ_TIMER: vector_of = psq_pkg::PSQ_VEC_TIMER;
      psq_pkg::PSQ_IRQ_EXT: vector_of = psq_pkg::PSQ_VEC_EXT;
      default: vector_of = psq_pkg::PSQ_VEC_RESET;
    endcase
  endfunction : vector_of

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  psq_return_stack u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(stk_push),
    .pop(stk_pop),
    .push_val(stk_push_val),
    .top_val(stk_top),
    .full(stk_full)
  );

  psq_table_addr u_tab (
    .page_ext_en(page_ext_en),
    .last_page(cmd.tab_last),
    .pc_high(s_q.pc[11:8]),
    .tbl_low(s_q.tbl_low),
    .tbl_page(s_q.tbl_page),
    .addr(tab_addr)
  );

  // ----------------------------------------------------------------
  // Request latching and acknowledge
  // ----------------------------------------------------------------
  // Requests are latched even while the stack is full; only the acknowledge waits.
  assign pend_now = s_q.pend | {s_q.ext_prev & ~ext_int_n, timer_ovf, serial_done};
  assign take_irq = (s_q.state == psq_pkg::PSQ_ST_RUN) && cmd.exec
                    && |(pend_now & irq_enable) && !stk_full;

  // Stack controls; the interrupt push saves the current PC, a call pushes PC plus one.
  assign stk_push = take_irq || ((s_q.state == psq_pkg::PSQ_ST_RUN) && cmd.exec && cmd.call);
  assign stk_pop = (s_q.state == psq_pkg::PSQ_ST_RUN) && cmd.exec && !take_irq
                   && (cmd.ret || cmd.interrupt_return_instr);
  assign stk_push_val = take_irq ? s_q.pc : s_q.pc + 12'd1;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One pass per instruction cycle; a branch spends a dummy cycle while the
  // new target is fetched, so the decoder must hold off on cycle_ready low.
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.tab_wr = 1'b0;
    s_d.dest_wr = 1'b0;
    s_d.ext_prev = ext_int_n;
    s_d.pend = pend_now;
    s_d.rdata = reg_read(reg_req.addr, s_q.tbl_low, s_q.tbl_high, s_q.tbl_page);
    if (reg_req.wr && reg_req.addr == psq_pkg::PSQ_OFS_TBL_LOW) begin
      s_d.tbl_low = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == psq_pkg::PSQ_OFS_TBL_PAGE) begin
      s_d.tbl_page = reg_req.wdata;
    end
    if (alu_wr) begin
      s_d.dest_data = alu_result;
      s_d.dest_wr = 1'b1;
      s_d.status = alu_status;
    end
    case (s_q.state)
      psq_pkg::PSQ_ST_RUN: begin
        s_d.cycle_ready = 1'b1;
        s_d.dummy = 1'b0;
        if (cmd.exec) begin
          if (take_irq) begin
            s_d.ack = 1'b1;
            s_d.vector = vector_of(lowest_first(pend_now & irq_enable));
            s_d.pend = pend_now & ~lowest_first(pend_now & irq_enable);
            s_d.pc = s_d.vector;
            s_d.state = psq_pkg::PSQ_ST_DUMMY;
          end else if (cmd.jump || cmd.call) begin
            s_d.pc = cmd.target;
            s_d.state = psq_pkg::PSQ_ST_DUMMY;
          end else if (cmd.ret || cmd.interrupt_return_instr) begin
            s_d.pc = stk_top;
            s_d.state = psq_pkg::PSQ_ST_DUMMY;
          end else if (cmd.pcl_wr) begin
            s_d.pc = {s_q.pc[11:8], reg_req.wdata};
            s_d.state = psq_pkg::PSQ_ST_DUMMY;
          end else if (cmd.skip) begin
            s_d.pc = s_q.pc + 12'd2;
            s_d.state = psq_pkg::PSQ_ST_DUMMY;
          end else if (cmd.tab_cur || cmd.tab_last) begin
            s_d.pmem_addr = tab_addr;
            s_d.state = psq_pkg::PSQ_ST_TABLE;
          end else begin
            s_d.pc = s_q.pc + 12'd1;
          end
          if (s_d.state != psq_pkg::PSQ_ST_RUN) begin
            s_d.cycle_ready = 1'b0;
            s_d.dummy = (s_d.state == psq_pkg::PSQ_ST_DUMMY);
          end
          if (s_d.state != psq_pkg::PSQ_ST_TABLE) begin
            s_d.pmem_addr = s_d.pc;
          end
        end
      end
      psq_pkg::PSQ_ST_TABLE: begin
        // Second cycle of a table read: the word is now on the memory bus.
        s_d.tab_data = pmem_rdata[7:0];
        s_d.tbl_high = {1'b0, pmem_rdata[14:8]};
        s_d.tab_wr = 1'b1;
        s_d.pc = s_q.pc + 12'd1;
        s_d.pmem_addr = s_d.pc;
        s_d.cycle_ready = 1'b1;
        s_d.state = psq_pkg::PSQ_ST_RUN;
      end
      psq_pkg::PSQ_ST_DUMMY: begin
        s_d.dummy = 1'b0;
        s_d.cycle_ready = 1'b1;
        s_d.state = psq_pkg::PSQ_ST_RUN;
      end
      default: begin
        s_d.pc = psq_pkg::PSQ_VEC_RESET;
        s_d.pmem_addr = psq_pkg::PSQ_VEC_RESET;
        s_d.cycle_ready = 1'b1;
        s_d.state = psq_pkg::PSQ_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.state <= psq_pkg::PSQ_ST_IDLE;
      s_q.pc <= psq_pkg::PSQ_VEC_RESET;
      s_q.pmem_addr <= psq_pkg::PSQ_VEC_RESET;
      s_q.tbl_low <= psq_pkg::PSQ_RST_TBL_LOW;
      s_q.tbl_high <= psq_pkg::PSQ_RST_TBL_HIGH;
      s_q.tbl_page <= psq_pkg::PSQ_RST_TBL_PAGE;
      s_q.ext_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pmem_addr = s_q.pmem_addr;
  assign pc = s_q.pc;
  assign cycle_ready = s_q.cycle_ready;
  assign dummy_cycle = s_q.dummy;
  assign irq_ack = s_q.ack;
  assign irq_vector = s_q.vector;
  assign irq_pending = s_q.pend;
  assign reg_rdata = s_q.rdata;
  assign tab_wr = s_q.tab_wr;
  assign tab_data = s_q.tab_data;
  assign dest_data = s_q.dest_data;
  assign dest_wr = s_q.dest_wr;
  assign status_q = s_q.status;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RESET_PC: assert property (@(posedge clk_sys)
    !rst_n |=> pc == 12'h000) else $error("pc not zero after reset");
  AST_FULL_NO_ACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stk_full && cmd.exec |=> !irq_ack) else $error("ack while stack full");
  AST_ACK_VECTOR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_ack |-> pc == irq_vector && (irq_vector == 12'h004 || irq_vector == 12'h008
    || irq_vector == 12'h00C)) else $error("bad vector");
  AST_SERIAL_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_irq && pend_now[0] && irq_enable[0] |=> irq_vector == 12'h004)
    else $error("serial not first");
  AST_JUMP_TARGET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_q.state == psq_pkg::PSQ_ST_RUN && cmd.exec && cmd.jump && !take_irq
    |=> pc == $past(cmd.target) && dummy_cycle ##1 cycle_ready) else $error("jump wrong");
  AST_PCL_PAGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_q.state == psq_pkg::PSQ_ST_RUN && cmd.exec && cmd.pcl_wr && !take_irq && !cmd.jump
    && !cmd.call && !cmd.ret && !cmd.interrupt_return_instr |=> pc[11:8] == $past(pc[11:8]))
    else $error("pcl write left page");
  AST_SKIP_TWO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_q.state == psq_pkg::PSQ_ST_RUN && cmd.exec && cmd.skip && !take_irq && !cmd.jump
    && !cmd.call && !cmd.ret && !cmd.interrupt_return_instr && !cmd.pcl_wr
    |=> pc == $past(pc) + 12'd2 && dummy_cycle) else $error("skip wrong");
  AST_TABLE_TWO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_q.state == psq_pkg::PSQ_ST_TABLE |=> tab_wr && cycle_ready && tbl_top_zero)
    else $error("table read not two cycles");
  AST_LAST_PAGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd.tab_last |-> tab_addr[11:8] == 4'hF) else $error("last page address");

  // The spare top bit of the high register must never be set by a table read.
  assign tbl_top_zero = !s_q.tbl_high[7];

  COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_ack);
  COV_TABLE: cover property (@(posedge clk_sys) disable iff (!rst_n) tab_wr);
  COV_FULL_WAIT: cover property (@(posedge clk_sys) disable iff (!rst_n)
    stk_full && |(pend_now & irq_enable) ##[1:20] irq_ack);

endmodule : psq_sequencer

// *** verif/psq_pmem_model.sv ***
// Behavioural program memory seen by the sequencer on its far side.
`timescale 1ns/1ps
module psq_pmem_model (
  input wire logic [11:0] addr,
  output logic [14:0] rdata
);
  // ----------------------------------------------------------------
  // Word pattern
  // ----------------------------------------------------------------
  // Every address gives its own 15-bit word, so a wrong address shows.
  // The read is combinational because the sequencer samples it in the
  // same cycle as its registered address.
  assign rdata = {addr[6:0], addr[11:4]} ^ 15'h2A5A;
endmodule : psq_pmem_model

// *** verif/test_psq_sequencer.sv ***
// Self-checking testbench for the program sequencer.
`timescale 1ns/1ps
module test_psq_sequencer;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [8:0] F_INC = 9'h100;
  localparam logic [8:0] F_JMP = 9'h180;
  localparam logic [8:0] F_CALL = 9'h140;
  localparam logic [8:0] F_RET = 9'h120;
  localparam logic [8:0] F_INTERRUPT_RETURN_INSTR = 9'h110;
  localparam logic [8:0] F_SKIP = 9'h108;
  localparam logic [8:0] F_PCL = 9'h104;
  localparam logic [8:0] F_TABC = 9'h102;
  localparam logic [8:0] F_TABL = 9'h101;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  psq_pkg::psq_cmd_t cmd = '0;
  psq_pkg::psq_reg_req_t reg_req = '0;
  logic [7:0] alu_result = 8'h00;
  logic [7:0] alu_status = 8'h00;
  logic alu_wr = 1'b0;
  logic serial_done = 1'b0;
  logic timer_ovf = 1'b0;
  logic ext_int_n = 1'b1;
  logic [2:0] irq_enable = 3'h7;
  logic page_ext_en = 1'b0;
  logic [14:0] pmem_rdata;
  logic [11:0] pmem_addr, pc, irq_vector, epc;
  logic cycle_ready, dummy_cycle, irq_ack, tab_wr, dest_wr;
  logic [2:0] irq_pending;
  logic [7:0] reg_rdata, tab_data, dest_data, status_q;
  int error_cnt = 0;
  int checks_done = 0;

  // The clock runs at 20 MHz.
  always #25 clk_sys = ~clk_sys;

  psq_sequencer dut (.clk_sys, .rst_n, .cmd, .reg_req, .alu_result, .alu_status,
    .alu_wr, .serial_done, .timer_ovf, .ext_int_n, .irq_enable, .page_ext_en,
    .pmem_rdata, .pmem_addr, .pc, .cycle_ready, .dummy_cycle, .irq_ack, .irq_vector,
    .irq_pending, .reg_rdata, .tab_wr, .tab_data, .dest_data, .dest_wr, .status_q);
  psq_pmem_model pmem (.addr(pmem_addr), .rdata(pmem_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // The release edge itself still shows the reset state; ready comes one edge later.
  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("pc", pc, 12'h000);
    chk("ready", cycle_ready, 1'b0);
    chk("pending", irq_pending, 3'h0);
    @(posedge clk_sys);
    #1;
    chk("pc", pc, 12'h000);
    chk("ready", cycle_ready, 1'b1);
    epc = 12'h000;
  endtask : do_reset

  // The command is held until an edge sees cycle_ready high; that edge takes it.
  // Ready is read 1 ns after an edge, so it is the value the next edge samples.
  task automatic issue(input logic [8:0] f, input logic [11:0] t);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd <= {f, t};
    #1;
    while (cycle_ready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    cmd <= '0;
    if (n >= 20) error_cnt++;
    #1;
  endtask : issue

  task automatic step(input logic [8:0] f, input logic [11:0] t, input logic [11:0] e,
                      input logic d);
    issue(f, t);
    chk("pc", pc, e);
    chk("dummy", dummy_cycle, d);
    epc = e;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_req <= {1'b0, a, d};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= {1'b0, a, 8'h00};
    @(posedge clk_sys);
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(8'h07, 8'h00);
    rd(8'h1F, 8'h00);
    wr(8'h07, 8'hA5);
    wr(8'h1F, 8'h3C);
    wr(8'h08, 8'hFF);
    rd(8'h07, 8'hA5);
    rd(8'h1F, 8'h3C);
    rd(8'h08, 8'h00);
    rd(8'h1E, 8'h00);
  endtask : t_regs

  task automatic t_alu;
    @(posedge clk_sys);
    alu_result <= 8'h5A;
    alu_status <= 8'h03;
    alu_wr <= 1'b1;
    @(posedge clk_sys);
    alu_wr <= 1'b0;
    #1;
    chk("dest_wr", dest_wr, 1'b1);
    chk("dest_data", dest_data, 8'h5A);
    chk("status", status_q, 8'h03);
  endtask : t_alu

  // The low byte write goes backwards inside the page to catch a carry into bit 8.
  task automatic t_flow;
    step(F_INC, 12'h000, 12'h001, 1'b0);
    step(F_JMP, 12'h5F0, 12'h5F0, 1'b1);
    step(F_SKIP, 12'h000, 12'h5F2, 1'b1);
    @(posedge clk_sys);
    reg_req <= {1'b0, 8'h1E, 8'h10};
    step(F_PCL, 12'h000, 12'h510, 1'b1);
    step(F_CALL, 12'h321, 12'h321, 1'b1);
    step(F_INC, 12'h000, 12'h322, 1'b0);
    step(F_RET, 12'h000, 12'h511, 1'b1);
  endtask : t_flow

  task automatic t_table;
    logic [11:0] a;
    logic [14:0] w;
    // No interrupt source fires here, as software keeps table reads unshared.
    wr(8'h07, 8'h34);
    wr(8'h1F, 8'hCA);
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys);
      page_ext_en <= (m == 1);
      a = (m == 0) ? {epc[11:8], 8'h34} : (m == 1) ? 12'hA34 : 12'hF34;
      w = {a[6:0], a[11:4]} ^ 15'h2A5A;
      issue((m == 2) ? F_TABL : F_TABC, 12'h000);
      chk("pmem_addr", pmem_addr, a);
      chk("ready", cycle_ready, 1'b0);
      @(posedge clk_sys);
      #1;
      chk("tab_wr", tab_wr, 1'b1);
      chk("tab_data", tab_data, w[7:0]);
      chk("ready", cycle_ready, 1'b1);
      chk("pc", pc, epc + 12'h001);
      epc = epc + 12'h001;
      rd(8'h08, {1'b0, w[14:8]});
    end
  endtask : t_table

  // All three sources fire together; they must be served lowest vector first.
  task automatic t_prio;
    @(posedge clk_sys);
    serial_done <= 1'b1;
    timer_ovf <= 1'b1;
    ext_int_n <= 1'b0;
    @(posedge clk_sys);
    serial_done <= 1'b0;
    timer_ovf <= 1'b0;
    ext_int_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("pending", irq_pending, 3'h7);
    step(F_INC, 12'h000, 12'h004, 1'b1);
    chk("ack", irq_ack, 1'b1);
    chk("pending", irq_pending, 3'h6);
    step(F_INC, 12'h000, 12'h008, 1'b1);
    chk("pending", irq_pending, 3'h4);
    step(F_INC, 12'h000, 12'h00C, 1'b1);
    chk("vector", irq_vector, 12'h00C);
    chk("pending", irq_pending, 3'h0);
    step(F_INTERRUPT_RETURN_INSTR, 12'h000, 12'h008, 1'b1);
  endtask : t_prio

  // Six calls fill the stack; the timer request must wait for a return.
  task automatic t_full;
    for (int i = 0; i < 6; i++) begin
      step(F_CALL, {8'h10, i[3:0]}, {8'h10, i[3:0]}, 1'b1);
    end
    @(posedge clk_sys);
    timer_ovf <= 1'b1;
    @(posedge clk_sys);
    timer_ovf <= 1'b0;
    step(F_INC, 12'h000, 12'h106, 1'b0);
    chk("ack", irq_ack, 1'b0);
    chk("pending", irq_pending, 3'h2);
    step(F_RET, 12'h000, 12'h105, 1'b1);
    step(F_INC, 12'h000, 12'h008, 1'b1);
    chk("ack", irq_ack, 1'b1);
    step(F_CALL, 12'h200, 12'h200, 1'b1);
  endtask : t_full

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_regs();
    t_alu();
    t_flow();
    t_table();
    do_reset();
    t_prio();
    do_reset();
    t_full();
    test_done();
  end

  // The tests need well under a thousand cycles, so this only trips on a hang.
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
endmodule : test_psq_sequencer
